// File: src/ovr_top.sv
// AHB-Lite over-range detector: per-channel flag pins, shared settings, interrupt.
//
// Behaviour
// - Each 9-bit sample yields an 8-bit magnitude compared against the threshold.
// - Magnitude is absolute value; -256 saturates to 255.
// - Magnitude at or above threshold sets the channel flag; below it the flag falls only once the hold runs out.
// - Detection runs only while the enable bit is 1.
// - One threshold serves all channels.
// - Four-channel variant drives A, B, C, D on four flag pins in order.
// - Two-channel variant drives A and B on the first two flag pins.
// - Single-channel variant drives only the first flag pin.
// - Flag holds 8 shifted by the 3-bit setting cycles after the last event.
// - Samples are signed two's complement codes.
// - Reference clock function wins over the flag on the third pin, and on the fourth pin only when the third also carries it.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
module ovr_top
	import ovr_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int REFCLK_HALF = OVR_REFCLK_HALF
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ovr_pkg::ovr_sample_s [ovr_pkg::OVR_MAX_CH-1:0] sample_in,
	output logic flag_out_a,
	output logic flag_out_b,
	output logic flag_out_c,
	output logic flag_out_d,
	output logic irq
);
	// Samples arrive from converter logic on this same clock, so no synchroniser.

	// Register state.
	logic overrange_detect_on_q, overrange_detect_on_d;
	logic [OVR_HOLD_SEL_W-1:0] overrange_hold_select_q, overrange_hold_select_d;
	logic refclk_out_c_function_q, refclk_out_c_function_d;
	logic refclk_out_d_function_q, refclk_out_d_function_d;
	logic [OVR_MAG_W-1:0] overrange_threshold_q, overrange_threshold_d;
	logic [OVR_MAX_CH-1:0] status_q, status_d;
	logic [OVR_MAX_CH-1:0] mask_q, mask_d;

	// Bus state.
	logic wr_pend_q, wr_pend_d;
	logic [OVR_ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic irq_q, irq_d;
	logic ready_q, ready_d;
	logic resp_q, resp_d;

	// Pin state.
	logic [OVR_MAX_CH-1:0] pins_q, pins_d;
	logic [3:0] div_cnt_q, div_cnt_d;
	logic refclk_q, refclk_d;

	// Channel outputs.
	logic [OVR_MAX_CH-1:0] ch_flag;
	logic [OVR_MAX_CH-1:0] ch_hit;

	logic accept;
	logic rd_status;
	logic [OVR_ADDR_W-1:0] addr;
	logic [5:0] ctrl_word;

	// Channels that exist in this variant get a detector; the rest stay silent.
	for (genvar i = 0; i < OVR_MAX_CH; i++)
	begin : g_ch
		if (i < NUM_CH)
		begin : g_live
			ovr_chan u_chan
			(
				.hclk(hclk),
				.hresetn(hresetn),
				.sample(sample_in[i]),
				.detect_on(overrange_detect_on_q),
				.threshold(overrange_threshold_q),
				.hold_select(overrange_hold_select_q),
				.flag(ch_flag[i]),
				.hit(ch_hit[i])
			);
		end
		else
		begin : g_dead
			assign ch_flag[i] = 1'b0;
			assign ch_hit[i] = 1'b0;
		end
	end

	// Address phase decode; only the low address bits select a register.
	// Transfer size is ignored: every register is one whole word.
	assign accept = hsel && htrans[OVR_HTRANS_ACTIVE_BIT] && hready;
	assign addr = {haddr[OVR_ADDR_W-1:2], 2'b00};
	assign rd_status = accept && !hwrite && addr == OVR_ADDR_STATUS;
	assign ctrl_word = {refclk_out_d_function_q, refclk_out_c_function_q,
		overrange_hold_select_q, overrange_detect_on_q};

	// Bus slave: reads answer from a register loaded in the address phase,
	// writes land in the data phase when hwdata is valid.
	always_comb
	begin
		wr_pend_d = accept && hwrite;
		wr_addr_d = accept ? addr : wr_addr_q;
		hrdata_d = hrdata_q;
		ready_d = 1'b1; // No wait states: every register answers in one cycle.
		resp_d = 1'b0; // Unmapped accesses are harmless, so there is no error response.
		if (accept && !hwrite)
		begin
			case (addr)
				OVR_ADDR_CTRL: hrdata_d = {26'h0, ctrl_word};
				OVR_ADDR_THRESH: hrdata_d = {24'h0, overrange_threshold_q};
				OVR_ADDR_STATUS: hrdata_d = {28'h0, status_q};
				OVR_ADDR_MASK: hrdata_d = {28'h0, mask_q};
				OVR_ADDR_FLAGS: hrdata_d = {28'h0, ch_flag};
				default: hrdata_d = 32'h0;
			endcase
		end
	end

	// Settings registers take the write data one cycle after the address phase.
	always_comb
	begin
		overrange_detect_on_d = overrange_detect_on_q;
		overrange_hold_select_d = overrange_hold_select_q;
		refclk_out_c_function_d = refclk_out_c_function_q;
		refclk_out_d_function_d = refclk_out_d_function_q;
		overrange_threshold_d = overrange_threshold_q;
		mask_d = mask_q;
		if (wr_pend_q)
		begin
			case (wr_addr_q)
				OVR_ADDR_CTRL:
				begin
					overrange_detect_on_d = hwdata[OVR_CTRL_ON_BIT];
					overrange_hold_select_d =
						hwdata[OVR_CTRL_HOLD_LSB +: OVR_HOLD_SEL_W];
					refclk_out_c_function_d = hwdata[OVR_CTRL_REFC_BIT];
					refclk_out_d_function_d = hwdata[OVR_CTRL_REFD_BIT];
				end
				OVR_ADDR_THRESH: overrange_threshold_d = hwdata[OVR_MAG_W-1:0];
				OVR_ADDR_MASK: mask_d = hwdata[OVR_MAX_CH-1:0];
				default: mask_d = mask_q;
			endcase
		end
	end

	// Sticky events; a read clears them, but a hit in the same cycle survives.
	always_comb
	begin
		status_d = status_q;
		if (rd_status)
			status_d = '0;
		status_d = status_d | ch_hit;
		irq_d = |(status_q & mask_q);
	end

	// Free-running reference clock that the third and fourth pins may carry.
	always_comb
	begin
		div_cnt_d = div_cnt_q + 4'h1;
		refclk_d = refclk_q;
		if (div_cnt_q == 4'(REFCLK_HALF - 1))
		begin
			div_cnt_d = 4'h0;
			refclk_d = !refclk_q;
		end
	end

	// Pin mux; the fourth pin's clock needs the third pin's clock enabled too.
	// Registering the pins adds one cycle but keeps the outputs glitch free.
	always_comb
	begin
		pins_d[0] = ch_flag[0];
		pins_d[1] = ch_flag[1];
		pins_d[2] = refclk_out_c_function_q ? refclk_q : ch_flag[2];
		pins_d[3] = (refclk_out_c_function_q && refclk_out_d_function_q) ?
			refclk_q : ch_flag[3];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			overrange_detect_on_q <= OVR_CTRL_RST[OVR_CTRL_ON_BIT];
			overrange_hold_select_q <= OVR_CTRL_RST[OVR_CTRL_HOLD_LSB +: OVR_HOLD_SEL_W];
			refclk_out_c_function_q <= OVR_CTRL_RST[OVR_CTRL_REFC_BIT];
			refclk_out_d_function_q <= OVR_CTRL_RST[OVR_CTRL_REFD_BIT];
			overrange_threshold_q <= OVR_THRESH_RST;
			status_q <= '0;
			mask_q <= OVR_MASK_RST;
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= 32'h0;
			irq_q <= 1'b0;
			ready_q <= 1'b1;
			resp_q <= 1'b0;
			pins_q <= '0;
			div_cnt_q <= 4'h0;
			refclk_q <= 1'b0;
		end
		else
		begin
			overrange_detect_on_q <= overrange_detect_on_d;
			overrange_hold_select_q <= overrange_hold_select_d;
			refclk_out_c_function_q <= refclk_out_c_function_d;
			refclk_out_d_function_q <= refclk_out_d_function_d;
			overrange_threshold_q <= overrange_threshold_d;
			status_q <= status_d;
			mask_q <= mask_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
			irq_q <= irq_d;
			ready_q <= ready_d;
			resp_q <= resp_d;
			pins_q <= pins_d;
			div_cnt_q <= div_cnt_d;
			refclk_q <= refclk_d;
		end
	end

	// The slave never stalls and never errors; both still leave from flops like every output.
	assign hreadyout = ready_q;
	assign hresp = resp_q;
	assign hrdata = hrdata_q;
	assign irq = irq_q;
	assign flag_out_a = pins_q[0];
	assign flag_out_b = pins_q[1];
	assign flag_out_c = pins_q[2];
	assign flag_out_d = pins_q[3];

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_ctrl_write;
		accept && hwrite && addr == OVR_ADDR_CTRL;
	endsequence

	sequence s_thresh_write;
		accept && hwrite && addr == OVR_ADDR_THRESH;
	endsequence

	sequence s_status_read;
		rd_status && ch_hit == '0;
	endsequence

	// Pins carry the channel flags in channel order, one cycle after the internal flag.
	a_pin_order: assert property (!refclk_out_c_function_q |=>
		flag_out_c == $past(ch_flag[2]) && flag_out_a == $past(ch_flag[0])
		&& flag_out_b == $past(ch_flag[1]))
		else $error("flag pins out of channel order");
	a_unused_quiet: assert property (NUM_CH < 2 |-> !flag_out_b)
		else $error("unused flag pin driven");
	// A narrow variant leaves the third pin low unless the clock owns it.
	a_unused_pin_c: assert property (NUM_CH < 4 && !refclk_out_c_function_q |=> !flag_out_c)
		else $error("third pin driven in a narrow variant");
	a_clock_wins: assert property (refclk_out_c_function_q |=> flag_out_c == $past(refclk_q))
		else $error("third pin not carrying the clock");
	// The fourth pin takes the clock only together with the third.
	a_clock_both: assert property (refclk_out_c_function_q && refclk_out_d_function_q |=>
		flag_out_d == $past(refclk_q))
		else $error("fourth pin not carrying the clock");
	a_refd_alone: assert property (refclk_out_d_function_q && !refclk_out_c_function_q |=>
		flag_out_d == $past(ch_flag[3]))
		else $error("fourth pin carried the clock alone");
	// Settings take effect at the end of the data phase.
	a_enable_write: assert property (s_ctrl_write ##1 1'b1 |=>
		overrange_detect_on_q == $past(hwdata[OVR_CTRL_ON_BIT]))
		else $error("enable bit not written");
	a_thresh_write: assert property (s_thresh_write ##1 1'b1 |=>
		overrange_threshold_q == $past(hwdata[OVR_MAG_W-1:0]))
		else $error("threshold not written");
	// The threshold reads back in the data phase of its read.
	a_thresh_read: assert property (accept && !hwrite && addr == OVR_ADDR_THRESH |=>
		hrdata == {24'h0, $past(overrange_threshold_q)})
		else $error("threshold read back wrong");
	// No channel may report a hit while detection is off.
	a_detect_gate: assert property (!overrange_detect_on_q |-> ch_hit == '0)
		else $error("hit reported while detection off");
	a_off_pins: assert property (
		(!overrange_detect_on_q && !refclk_out_c_function_q) [*3] |-> !flag_out_a && !flag_out_c)
		else $error("flag pin high while detection off");
	// Events reach status one cycle after the hit and the interrupt one cycle after that.
	a_hit_sticky: assert property (ch_hit[0] |=> status_q[0])
		else $error("event lost from status");
	a_status_clear: assert property (s_status_read |=> status_q == '0)
		else $error("status not cleared by its read");
	a_irq_level: assert property (|(status_q & mask_q) |=> irq)
		else $error("interrupt not raised");
	a_irq_quiet: assert property (!(|(status_q & mask_q)) |=> !irq)
		else $error("interrupt raised without a masked event");
endmodule

// File: src/ovr_pkg.sv
// Package with constants, register map and carrier types of the over-range detector.
package ovr_pkg;

	// Channel count of the widest variant and sample widths.
	localparam int OVR_MAX_CH = 4;
	localparam int OVR_CODE_W = 9;
	localparam int OVR_MAG_W = 8;
	localparam int OVR_HOLD_SEL_W = 3;
	localparam int OVR_CNT_W = 11;

	// Hold length at setting 0, in sample-clock cycles; each step doubles it.
	localparam logic [OVR_CNT_W-1:0] OVR_HOLD_BASE = 11'h008;

	// Largest magnitude; the most negative code saturates to it.
	localparam logic [OVR_MAG_W-1:0] OVR_MAG_MAX = 8'hff;
	localparam logic [OVR_CODE_W-1:0] OVR_CODE_MIN = 9'h100;

	// Register byte offsets on the bus.
	localparam int OVR_ADDR_W = 8;
	localparam logic [OVR_ADDR_W-1:0] OVR_ADDR_CTRL = 8'h00;
	localparam logic [OVR_ADDR_W-1:0] OVR_ADDR_THRESH = 8'h04;
	localparam logic [OVR_ADDR_W-1:0] OVR_ADDR_STATUS = 8'h08;
	localparam logic [OVR_ADDR_W-1:0] OVR_ADDR_MASK = 8'h0c;
	localparam logic [OVR_ADDR_W-1:0] OVR_ADDR_FLAGS = 8'h10;

	// Control register field positions.
	localparam int OVR_CTRL_ON_BIT = 0;
	localparam int OVR_CTRL_HOLD_LSB = 1;
	localparam int OVR_CTRL_REFC_BIT = 4;
	localparam int OVR_CTRL_REFD_BIT = 5;

	// Reset values.
	localparam logic [5:0] OVR_CTRL_RST = 6'h00;
	localparam logic [OVR_MAG_W-1:0] OVR_THRESH_RST = 8'hff;
	localparam logic [OVR_MAX_CH-1:0] OVR_MASK_RST = 4'h0;

	// Half period of the reference clock on the shared pins, in bus-clock cycles.
	localparam int OVR_REFCLK_HALF = 2;

	// AHB transfer type bit that marks NONSEQ or SEQ.
	localparam int OVR_HTRANS_ACTIVE_BIT = 1;

	// One converter sample with its valid strobe.
	typedef struct packed
	{
		logic valid;
		logic [OVR_CODE_W-1:0] code;
	} ovr_sample_s;

endpackage

// File: src/ovr_chan.sv
// One channel of the over-range detector: magnitude, compare and hold counter.
module ovr_chan
	import ovr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire ovr_pkg::ovr_sample_s sample,
	input wire logic detect_on,
	input wire logic [ovr_pkg::OVR_MAG_W-1:0] threshold,
	input wire logic [ovr_pkg::OVR_HOLD_SEL_W-1:0] hold_select,
	output logic flag,
	output logic hit
);
	logic [OVR_MAG_W-1:0] mag;
	logic [OVR_CODE_W-1:0] neg;
	logic [OVR_CNT_W-1:0] hold_len;
	logic [OVR_CNT_W-1:0] cnt_q, cnt_d;
	logic flag_q, flag_d;

	// Signed code to magnitude; the lone code without a positive twin saturates.
	always_comb
	begin
		neg = 9'h000 - sample.code;
		if (sample.code == OVR_CODE_MIN)
			mag = OVR_MAG_MAX;
		else if (sample.code[OVR_CODE_W-1])
			mag = neg[OVR_MAG_W-1:0];
		else
			mag = sample.code[OVR_MAG_W-1:0];
	end

	// A hit needs a valid sample, detection on and magnitude at or above threshold.
	assign hit = sample.valid && detect_on && (mag >= threshold);
	assign hold_len = OVR_HOLD_BASE << hold_select;

	// Every hit restarts the window, so the flag counts from the latest event.
	always_comb
	begin
		cnt_d = cnt_q;
		flag_d = flag_q;
		if (!detect_on)
		begin
			cnt_d = '0;
			flag_d = 1'b0;
		end
		else if (hit)
		begin
			cnt_d = hold_len - 11'h001;
			flag_d = 1'b1;
		end
		else if (cnt_q != '0)
		begin
			cnt_d = cnt_q - 11'h001;
			flag_d = 1'b1;
		end
		else
			flag_d = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_q <= '0;
			flag_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_hit_short;
		hit && hold_select == 3'h0;
	endsequence

	sequence s_quiet_short;
		(!hit && detect_on && hold_select == 3'h0) [*8];
	endsequence

	a_flag_on_hit: assert property (hit |=> flag)
		else $error("flag not raised after a hit");
	a_hold_ends: assert property (s_hit_short ##1 s_quiet_short |=> !flag)
		else $error("flag held past eight cycles");
	a_hold_stays: assert property (s_hit_short ##1 (!hit && detect_on) [*7] |-> flag)
		else $error("flag dropped before eight cycles");
	a_hold_load: assert property (hit |=> cnt_q == $past(hold_len) - 11'h001)
		else $error("hold count loaded wrong");
	a_neg_sat: assert property (sample.code == OVR_CODE_MIN |-> mag == OVR_MAG_MAX)
		else $error("most negative code not saturated");
	a_off_quiet: assert property (!detect_on |=> !flag && cnt_q == '0)
		else $error("flag active while detection off");
endmodule

// File: bench/ovr_gain_ctl.sv
// Downstream gain-control model that watches the over-range flag pins.
module ovr_gain_ctl
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] flags,
	output logic gain_low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] quiet_q;
	// Gain drops on any flag and rises only after a quiet spell of our own choosing.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gain_low <= 1'b0;
			quiet_q <= 5'h00;
		end
		else if (|flags)
		begin
			gain_low <= 1'b1;
			quiet_q <= 5'h00;
		end
		else if (quiet_q == 5'h1f)
			gain_low <= 1'b0;
		else
			quiet_q <= quiet_q + 5'h01;
	end
endmodule

// File: bench/ovr_top_test.sv
// Self-checking bench of the over-range detector and its three channel-count variants.
module ovr_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import ovr_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, gain_low;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	wire logic [3:0] f4, f2, f1;
	ovr_pkg::ovr_sample_s [3:0] smp;
	int num_errors = 0;
	int total_checks = 0;
	// The single slave's ready is the bus ready.
	wire logic hready = hreadyout;
	ovr_top ovr_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_in(smp),
		.flag_out_a(f4[0]), .flag_out_b(f4[1]), .flag_out_c(f4[2]), .flag_out_d(f4[3]), .irq(irq));
	// Narrow variants see the same bus writes and samples; only their pins are watched.
	ovr_top #(.NUM_CH(2)) ovr_top_inst2 (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(), .hresp(), .hrdata(), .sample_in(smp),
		.flag_out_a(f2[0]), .flag_out_b(f2[1]), .flag_out_c(f2[2]), .flag_out_d(f2[3]), .irq());
	ovr_top #(.NUM_CH(1)) ovr_top_inst1 (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(), .hresp(), .hrdata(), .sample_in(smp),
		.flag_out_a(f1[0]), .flag_out_b(f1[1]), .flag_out_c(f1[2]), .flag_out_d(f1[3]), .irq());
	ovr_gain_ctl ovr_gain_ctl_inst (.hclk(hclk), .hresetn(hresetn), .flags(f4),
		.gain_low(gain_low));
	// Clock of 100 ns period.
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits for ready at a rising edge; a wait that runs out ends the run.
	task automatic wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			num_errors++;
			give_verdict();
		end
	endtask
	// One single-word AHB-Lite transfer: address phase, then data phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rv = hrdata;
	endtask
	task automatic hit(input int ch, input logic [8:0] c);
		smp[ch] <= '{1'b1, c};
		@(posedge hclk);
		smp[ch].valid <= 1'b0;
	endtask
	task automatic t_regs;
		int i;
		logic [7:0] adr [5] = '{OVR_ADDR_CTRL, OVR_ADDR_THRESH, OVR_ADDR_STATUS, OVR_ADDR_MASK, 8'h20};
		logic [31:0] exp [5] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0};
		for (i = 0; i < 5; i++)
		begin
			bus(1'b0, adr[i], 32'h0);
			check(rv, exp[i]);
		end
		$display("test regs done");
	endtask
	// Threshold, code and expected hit, from the magnitude conversion table.
	task automatic t_mag;
		int i;
		logic [17:0] tb [8] = '{{8'hff, 9'h0ff, 1'b1}, {8'hff, 9'h100, 1'b1},
			{8'hff, 9'h102, 1'b0}, {8'hfe, 9'h102, 1'b1}, {8'hfe, 9'h0fe, 1'b1},
			{8'hfe, 9'h0fd, 1'b0}, {8'h01, 9'h000, 1'b0}, {8'h01, 9'h1ff, 1'b1}};
		for (i = 0; i < 8; i++)
		begin
			bus(1'b1, OVR_ADDR_THRESH, {24'h0, tb[i][17:10]});
			hit(0, tb[i][9:1]);
			bus(1'b0, OVR_ADDR_STATUS, 32'h0);
			check(rv, {31'h0, tb[i][0]});
		end
		$display("test magnitude done");
	endtask
	task automatic t_hold(input logic [2:0] sel, input logic twice);
		int n;
		bus(1'b1, OVR_ADDR_CTRL, {28'h0, sel, 1'b1});
		bus(1'b1, OVR_ADDR_THRESH, 32'he4);
		hit(0, 9'h0f0);
		if (twice)
		begin
			repeat (4) @(posedge hclk);
			hit(0, 9'h0f0);
		end
		n = 0;
		while (n < 2000)
		begin
			@(posedge hclk);
			#1;
			if (f4[0] !== 1'b1)
				break;
			n++;
		end
		check(n, 8 << sel);
		@(posedge hclk);
		$display("test hold %0d done", sel);
	endtask
	task automatic t_chan;
		int i;
		bus(1'b1, OVR_ADDR_CTRL, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			hit(i, 9'h110);
			@(posedge hclk);
			#1;
			check(f4, 4'h1 << i);
			check(f2, (4'h1 << i) & 4'h3);
			check(f1, (4'h1 << i) & 4'h1);
			repeat (12) @(posedge hclk);
		end
		bus(1'b0, OVR_ADDR_STATUS, 32'h0);
		check(rv, 32'hf);
		$display("test channels done");
	endtask
	task automatic t_off;
		bus(1'b1, OVR_ADDR_CTRL, 32'h0);
		hit(0, 9'h0ff);
		repeat (2) @(posedge hclk);
		check(f4, 4'h0);
		bus(1'b0, OVR_ADDR_STATUS, 32'h0);
		check(rv, 32'h0);
		bus(1'b1, OVR_ADDR_CTRL, 32'hf);
		hit(0, 9'h0ff);
		repeat (3) @(posedge hclk);
		check(f4, 4'h1);
		bus(1'b0, OVR_ADDR_FLAGS, 32'h0);
		check(rv, 32'h1);
		bus(1'b1, OVR_ADDR_CTRL, 32'he);
		repeat (3) @(posedge hclk);
		check(f4, 4'h0);
		bus(1'b1, OVR_ADDR_CTRL, 32'hf);
		repeat (3) @(posedge hclk);
		check(f4, 4'h0);
		bus(1'b0, OVR_ADDR_STATUS, 32'h0);
		$display("test disable done");
	endtask
	task automatic t_irq;
		bus(1'b1, OVR_ADDR_CTRL, 32'h1);
		bus(1'b1, OVR_ADDR_MASK, 32'h1);
		hit(1, 9'h0f0);
		repeat (3) @(posedge hclk);
		check(irq, 1'b0);
		bus(1'b0, OVR_ADDR_STATUS, 32'h0);
		check(rv, 32'h2);
		hit(0, 9'h0f0);
		repeat (3) @(posedge hclk);
		check(irq, 1'b1);
		check(gain_low, 1'b1);
		bus(1'b0, OVR_ADDR_STATUS, 32'h0);
		check(rv, 32'h1);
		repeat (2) @(posedge hclk);
		check(irq, 1'b0);
		repeat (50) @(posedge hclk);
		check(gain_low, 1'b0);
		$display("test interrupt done");
	endtask
	task automatic t_refclk;
		int tc, td;
		logic pc, pd;
		tc = 0;
		td = 0;
		bus(1'b1, OVR_ADDR_CTRL, 32'h31);
		hit(2, 9'h0ff);
		pc = f4[2];
		pd = f4[3];
		repeat (16)
		begin
			@(posedge hclk);
			#1;
			tc += (f4[2] !== pc);
			td += (f4[3] !== pd);
			pc = f4[2];
			pd = f4[3];
		end
		check(tc >= 7, 1'b1);
		check(td >= 7, 1'b1);
		@(posedge hclk);
		// Fourth pin clock alone is refused: the pin keeps its flag, sampled half a period apart.
		bus(1'b1, OVR_ADDR_CTRL, 32'h21);
		hit(3, 9'h0ff);
		repeat (2) @(posedge hclk);
		check(f4, 4'h8);
		repeat (2) @(posedge hclk);
		check(f4, 4'h8);
		bus(1'b1, OVR_ADDR_CTRL, 32'h1);
		$display("test clock pins done");
	endtask
	// Reset in mid-run clears the pins and restores the register defaults.
	task automatic t_reset;
		bus(1'b1, OVR_ADDR_THRESH, 32'h80);
		hit(0, 9'h0ff);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check(f4, 4'h0);
		check(irq, 1'b0);
		bus(1'b0, OVR_ADDR_THRESH, 32'h0);
		check(rv, 32'hff);
		bus(1'b0, OVR_ADDR_STATUS, 32'h0);
		check(rv, 32'h0);
		$display("test reset done");
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		smp = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		bus(1'b1, OVR_ADDR_CTRL, 32'h1);
		t_mag();
		t_hold(3'h0, 1'b0);
		t_hold(3'h0, 1'b1);
		t_hold(3'h1, 1'b0);
		t_hold(3'h7, 1'b0);
		t_chan();
		t_off();
		t_irq();
		t_refclk();
		t_reset();
		give_verdict();
	end
endmodule
